/* rtl/sbc_pkg.sv */
// constants, types and carriers for the packed-subtract / coproc-store unit
package sbc_pkg;
	// register byte offsets on the bus
	localparam int AW = 8;
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_OPA = 8'h04;
	localparam logic [7:0] OFS_OPB = 8'h08;
	localparam logic [7:0] OFS_BASE = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_RES = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_WBK = 8'h1C;
	// control bit positions
	localparam int CTL_GO = 0;
	localparam int CTL_COND = 1;
	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_UNDEF = 1;
	localparam int ST_UNPRED = 2;
	localparam int ST_FAULT = 3;
	localparam int ST_XFER2 = 4;
	localparam int ST_WBACK = 5;
	localparam int ST_DONE = 6;
	localparam int ST_GE_LSB = 8;
	// opcode masks and matches, first halfword in bits 31:16
	localparam logic [31:0] BAR_MASK = 32'hFFF0_D0FF;
	localparam logic [31:0] BAR_MATCH = 32'hF3B0_8040;
	localparam logic [31:0] PSUB_MASK = 32'hFFF0_F0F0;
	localparam logic [31:0] S16_MATCH = 32'hFAD0_F000;
	localparam logic [31:0] S8_MATCH = 32'hFAC0_F000;
	localparam logic [31:0] CPS_MASK = 32'hEE10_0000;
	localparam logic [31:0] CPS_MATCH = 32'hEC00_0000;
	localparam logic [3:0] REG_SP = 4'hD;
	localparam logic [3:0] REG_PC = 4'hF;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SBC_IDLE,
		SBC_BARRIER,
		SBC_CP_REQ,
		SBC_CP_STORE
	} sbc_state_t;

	// bus inputs from the master
	typedef struct packed {
		logic awvalid;
		logic [AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AW-1:0] araddr;
		logic rready;
	} sbc_axi_in_t;

	// bus outputs to the master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sbc_axi_out_t;

	// all state of the unit
	typedef struct packed {
		sbc_axi_out_t axo;
		logic aw_got;
		logic w_got;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] instr;
		logic [31:0] opa;
		logic [31:0] opb;
		logic [31:0] base;
		logic cond;
		logic [31:0] res;
		logic [31:0] wbk;
		logic [3:0] ge;
		logic [6:0] stat;
		sbc_state_t state;
		logic [31:0] addr;
		logic [31:0] offs_addr;
		logic wback;
		logic barrier;
		logic cp_req;
		logic cp_pull;
		logic mem_wr;
		logic [31:0] mem_addr;
		logic [31:0] mem_data;
	} sbc_regs_t;

	localparam sbc_regs_t REGS_RST = '0;
endpackage : sbc_pkg

/* rtl/sbc_unit.sv */
// decode and execute unit: barrier, packed subtracts, coproc store
`timescale 1ns/1ps
module sbc_unit (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire sbc_pkg::sbc_axi_in_t axi_i,
	output sbc_pkg::sbc_axi_out_t axi_o,
	output logic barrier_o,
	output logic cp_req_o,
	output logic [3:0] cp_num_o,
	output logic [3:0] cp_src_reg_o,
	output logic cp_long_o,
	output logic cp_alt_o,
	output logic [7:0] cp_option_o,
	input wire logic cp_resp_i,
	input wire logic cp_accept_i,
	output logic cp_pull_o,
	input wire logic cp_word_valid_i,
	input wire logic [31:0] cp_word_i,
	input wire logic cp_done_i,
	output logic mem_wr_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_data_o,
	output logic usage_fault_a_o
);
	sbc_pkg::sbc_regs_t r_reg;
	sbc_pkg::sbc_regs_t r_next;
	logic [8:0] d8 [4];
	logic [16:0] d16 [2];
	logic [31:0] diff8;
	logic [31:0] diff16;
	logic [3:0] ge8;
	logic [3:0] ge16;
	logic go_fire;
	logic is_bar;
	logic is_s16;
	logic is_s8;
	logic is_cps;
	logic [3:0] rn;
	logic [3:0] rd;
	logic [3:0] rm;
	logic bp;
	logic bu;
	logic bn;
	logic bw;
	logic [31:0] imm32;
	logic [31:0] offs;

	// per-lane signed differences, one extra bit for the sign
	genvar i;
	for (i = 0; i < 4; i++)
	begin : g_lane
		assign d8[i] = {r_reg.opa[8*i+7], r_reg.opa[8*i+:8]}
			- {r_reg.opb[8*i+7], r_reg.opb[8*i+:8]};
		assign diff8[8*i+:8] = d8[i][7:0];
		assign ge8[i] = ~d8[i][8];
		if (i < 2)
		begin : g_half
			assign d16[i] = {r_reg.opa[16*i+15], r_reg.opa[16*i+:16]}
				- {r_reg.opb[16*i+15], r_reg.opb[16*i+:16]};
			assign diff16[16*i+:16] = d16[i][15:0];
			assign ge16[2*i+:2] = {2{~d16[i][16]}};
		end
	end

	// instruction fields and opcode matches
	assign rn = r_reg.instr[19:16];
	assign rd = r_reg.instr[11:8];
	assign rm = r_reg.instr[3:0];
	assign bp = r_reg.instr[24];
	assign bu = r_reg.instr[23];
	assign bn = r_reg.instr[22];
	assign bw = r_reg.instr[21];
	assign is_bar = (r_reg.instr & sbc_pkg::BAR_MASK) == sbc_pkg::BAR_MATCH;
	assign is_s16 = (r_reg.instr & sbc_pkg::PSUB_MASK) == sbc_pkg::S16_MATCH;
	assign is_s8 = (r_reg.instr & sbc_pkg::PSUB_MASK) == sbc_pkg::S8_MATCH;
	assign is_cps = (r_reg.instr & sbc_pkg::CPS_MASK) == sbc_pkg::CPS_MATCH;
	assign imm32 = {22'h000000, r_reg.instr[7:0], 2'h0};
	// add or subtract the scaled offset
	assign offs = bu ? (r_reg.base + imm32) : (r_reg.base - imm32);

	// next-state logic: bus slave, decoder and store sequencer
	always_comb
	begin
		r_next = r_reg;
		go_fire = 1'b0;
		r_next.barrier = 1'b0;
		r_next.mem_wr = 1'b0;
		// write address and data taken in either order
		if (axi_i.awvalid && r_reg.axo.awready)
		begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = axi_i.awaddr;
		end
		if (axi_i.wvalid && r_reg.axo.wready)
		begin
			r_next.w_got = 1'b1;
			r_next.wdata = axi_i.wdata;
			r_next.wstrb = axi_i.wstrb;
		end
		if (r_reg.axo.bvalid && axi_i.bready)
			r_next.axo.bvalid = 1'b0;
		// register write once both halves are in
		if (r_reg.aw_got && r_reg.w_got && !r_reg.axo.bvalid)
		begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.axo.bvalid = 1'b1;
			r_next.axo.bresp = sbc_pkg::RESP_OK;
			for (int b = 0; b < 4; b++)
			begin
				if (r_reg.wstrb[b])
				begin
					case (r_reg.awaddr)
						sbc_pkg::OFS_INSTR:
							r_next.instr[8*b+:8] = r_reg.wdata[8*b+:8];
						sbc_pkg::OFS_OPA:
							r_next.opa[8*b+:8] = r_reg.wdata[8*b+:8];
						sbc_pkg::OFS_OPB:
							r_next.opb[8*b+:8] = r_reg.wdata[8*b+:8];
						sbc_pkg::OFS_BASE:
							r_next.base[8*b+:8] = r_reg.wdata[8*b+:8];
						default:
							r_next.axo.bresp = r_reg.axo.bresp;
					endcase
				end
			end
			case (r_reg.awaddr)
				sbc_pkg::OFS_INSTR, sbc_pkg::OFS_OPA, sbc_pkg::OFS_OPB,
				sbc_pkg::OFS_BASE, sbc_pkg::OFS_STAT, sbc_pkg::OFS_RES,
				sbc_pkg::OFS_WBK:
					r_next.axo.bresp = sbc_pkg::RESP_OK;
				sbc_pkg::OFS_CTRL:
				begin
					r_next.axo.bresp = sbc_pkg::RESP_OK;
					if (r_reg.wstrb[0])
					begin
						r_next.cond = r_reg.wdata[sbc_pkg::CTL_COND];
						// go ignored while a sequence runs
						go_fire = r_reg.wdata[sbc_pkg::CTL_GO]
							&& r_reg.state == sbc_pkg::SBC_IDLE;
					end
				end
				default:
					r_next.axo.bresp = sbc_pkg::RESP_SLVERR;
			endcase
		end
		r_next.axo.awready = !r_next.aw_got && !r_next.axo.bvalid;
		r_next.axo.wready = !r_next.w_got && !r_next.axo.bvalid;
		// reads: one at a time, unmapped gives an error
		if (r_reg.axo.rvalid && axi_i.rready)
			r_next.axo.rvalid = 1'b0;
		if (axi_i.arvalid && r_reg.axo.arready)
		begin
			r_next.axo.rvalid = 1'b1;
			r_next.axo.rresp = sbc_pkg::RESP_OK;
			case (axi_i.araddr)
				sbc_pkg::OFS_INSTR: r_next.axo.rdata = r_reg.instr;
				sbc_pkg::OFS_OPA: r_next.axo.rdata = r_reg.opa;
				sbc_pkg::OFS_OPB: r_next.axo.rdata = r_reg.opb;
				sbc_pkg::OFS_BASE: r_next.axo.rdata = r_reg.base;
				sbc_pkg::OFS_CTRL: r_next.axo.rdata = {30'h0, r_reg.cond, 1'b0};
				sbc_pkg::OFS_RES: r_next.axo.rdata = r_reg.res;
				sbc_pkg::OFS_STAT:
					r_next.axo.rdata = {20'h0, r_reg.ge, 1'b0, r_reg.stat};
				sbc_pkg::OFS_WBK: r_next.axo.rdata = r_reg.wbk;
				default:
				begin
					r_next.axo.rdata = 32'h0000_0000;
					r_next.axo.rresp = sbc_pkg::RESP_SLVERR;
				end
			endcase
		end
		r_next.axo.arready = !r_next.axo.rvalid;
		// decoder and sequencer
		case (r_reg.state)
			sbc_pkg::SBC_IDLE:
			begin
				if (go_fire)
				begin
					r_next.stat = 7'h00;
					r_next.stat[sbc_pkg::ST_DONE] = 1'b1;
					if (is_bar)
					begin
						r_next.state = sbc_pkg::SBC_BARRIER;
						r_next.barrier = 1'b1;
						r_next.stat[sbc_pkg::ST_DONE] = 1'b0;
						r_next.stat[sbc_pkg::ST_UNPRED] = r_next.cond;
					end
					else if (is_s16 || is_s8)
					begin
						r_next.res = is_s16 ? diff16 : diff8;
						r_next.ge = is_s16 ? ge16 : ge8;
						r_next.stat[sbc_pkg::ST_UNPRED] =
							rd == sbc_pkg::REG_SP || rd == sbc_pkg::REG_PC
							|| rn == sbc_pkg::REG_SP || rn == sbc_pkg::REG_PC
							|| rm == sbc_pkg::REG_SP || rm == sbc_pkg::REG_PC;
					end
					else if (is_cps && !bp && !bu && !bw)
					begin
						r_next.stat[sbc_pkg::ST_UNDEF] = !bn;
						r_next.stat[sbc_pkg::ST_XFER2] = bn;
					end
					else if (is_cps)
					begin
						r_next.stat[sbc_pkg::ST_UNPRED] = rn == sbc_pkg::REG_PC;
						// index picks offset or base start
						r_next.addr = bp ? offs : r_reg.base;
						r_next.offs_addr = offs;
						r_next.wback = bw;
						r_next.stat[sbc_pkg::ST_DONE] = 1'b0;
						r_next.state = sbc_pkg::SBC_CP_REQ;
						r_next.cp_req = 1'b1;
					end
					else
						r_next.stat[sbc_pkg::ST_UNDEF] = 1'b1;
				end
			end
			sbc_pkg::SBC_BARRIER:
			begin
				// no store issued in the fence cycle
				r_next.state = sbc_pkg::SBC_IDLE;
				r_next.stat[sbc_pkg::ST_DONE] = 1'b1;
			end
			sbc_pkg::SBC_CP_REQ:
			begin
				if (cp_resp_i)
				begin
					r_next.cp_req = 1'b0;
					if (cp_accept_i)
					begin
						r_next.state = sbc_pkg::SBC_CP_STORE;
						r_next.cp_pull = 1'b1;
					end
					else
					begin
						r_next.stat[sbc_pkg::ST_FAULT] = 1'b1;
						r_next.stat[sbc_pkg::ST_DONE] = 1'b1;
						r_next.state = sbc_pkg::SBC_IDLE;
					end
				end
			end
			sbc_pkg::SBC_CP_STORE:
			begin
				if (cp_word_valid_i)
				begin
					// one word, address steps by four
					r_next.mem_wr = 1'b1;
					r_next.mem_addr = r_reg.addr;
					r_next.mem_data = cp_word_i;
					r_next.addr = r_reg.addr + sbc_pkg::ADDR_STEP;
					if (cp_done_i)
					begin
						r_next.cp_pull = 1'b0;
						r_next.state = sbc_pkg::SBC_IDLE;
						r_next.stat[sbc_pkg::ST_DONE] = 1'b1;
						r_next.stat[sbc_pkg::ST_WBACK] = r_reg.wback;
						r_next.wbk = r_reg.wback ? r_reg.offs_addr : r_reg.base;
					end
				end
			end
			default:
				r_next.state = sbc_pkg::SBC_IDLE;
		endcase
		r_next.stat[sbc_pkg::ST_BUSY] = r_next.state != sbc_pkg::SBC_IDLE;
	end

	// state register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			r_reg <= sbc_pkg::REGS_RST;
		else
			r_reg <= r_next;
	end

	// outputs straight from the state register
	assign axi_o = r_reg.axo;
	assign barrier_o = r_reg.barrier;
	assign cp_req_o = r_reg.cp_req;
	assign cp_pull_o = r_reg.cp_pull;
	assign cp_num_o = r_reg.instr[11:8];
	assign cp_src_reg_o = r_reg.instr[15:12];
	assign cp_long_o = r_reg.instr[22];
	assign cp_alt_o = r_reg.instr[28];
	// option byte for the unindexed form
	assign cp_option_o = r_reg.instr[7:0];
	assign mem_wr_o = r_reg.mem_wr;
	assign mem_addr_o = r_reg.mem_addr;
	assign mem_data_o = r_reg.mem_data;
	assign usage_fault_a_o = r_reg.stat[sbc_pkg::ST_FAULT];

	// checks on the unit's own behaviour
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_SUB16_RES: assert property (go_fire && is_s16 |=>
		r_reg.res[31:16] == $past(r_reg.opa[31:16]) - $past(r_reg.opb[31:16]))
		else $error("halfword difference wrong");
	AST_GE16: assert property (go_fire && is_s16 |=>
		r_reg.ge[1:0] == ($signed($past(r_reg.opa[15:0]))
		>= $signed($past(r_reg.opb[15:0])) ? 2'h3 : 2'h0))
		else $error("halfword flags wrong");
	AST_GE8: assert property (go_fire && is_s8 |=>
		r_reg.ge[3] == ($signed($past(r_reg.opa[31:24]))
		>= $signed($past(r_reg.opb[31:24]))))
		else $error("byte flag wrong");
	AST_UNDEF: assert property (go_fire && is_cps && !bp && !bu
		&& !bn && !bw |=> r_reg.stat[1] && !cp_req_o)
		else $error("undefined form not flagged");
	AST_XFER2: assert property (go_fire && is_cps && !bp && !bu
		&& bn && !bw |=> r_reg.stat[4] && !r_reg.stat[1])
		else $error("transfer redirect missing");
	AST_NO_WR_FAULT: assert property (cp_req_o && cp_resp_i
		&& !cp_accept_i |=> usage_fault_a_o && !mem_wr_o ##1 !mem_wr_o)
		else $error("refused store not faulted");
	AST_STEP: assert property (r_reg.state == sbc_pkg::SBC_CP_STORE
		&& cp_word_valid_i |=> mem_wr_o
		&& r_reg.addr == mem_addr_o + 32'h0000_0004)
		else $error("store step wrong");
	AST_PSUB_REGS: assert property (go_fire && is_s8
		&& (rd == sbc_pkg::REG_SP || rd == sbc_pkg::REG_PC)
		|=> r_reg.stat[2])
		else $error("pc destination not flagged");
	AST_BASE_PC: assert property (go_fire && is_cps
		&& (bp || bu || bw) && rn == sbc_pkg::REG_PC
		|=> r_reg.stat[2] ##1 cp_req_o)
		else $error("pc base not flagged");
	AST_FENCE: assert property ($rose(barrier_o) |->
		!mem_wr_o && !cp_pull_o ##1 !barrier_o && !mem_wr_o)
		else $error("store during fence");
	AST_START: assert property (go_fire && is_cps && bp && bw
		|=> r_reg.addr == r_reg.offs_addr)
		else $error("pre-index start wrong");
endmodule : sbc_unit

/* tb/sbc_cp_model.sv */
// coprocessor model: answers store offers and hands over words
`timescale 1ns/1ps
module sbc_cp_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic pull_i,
	input wire logic acc_i,
	input wire logic [3:0] nw_i,
	input wire logic [3:0] gap_i,
	input wire logic [3:0] dly_i,
	output logic resp_o,
	output logic accept_o,
	output logic wv_o,
	output logic [31:0] word_o,
	output logic done_o
);
	logic [3:0] rc;
	logic [3:0] gc;
	logic [3:0] sent;
	// accept or refuse
	// the answer bit is garbage while no answer stands
	assign accept_o = resp_o ? acc_i : ~acc_i;
	// one-cycle answer after a programmable delay
	always @(posedge clk_i)
	begin
		if (!rst_n_i || !req_i || resp_o)
		begin
			resp_o <= 1'b0;
			rc <= 4'h0;
		end
		else if (rc == dly_i)
			resp_o <= 1'b1;
		else
			rc <= rc + 4'h1;
	end
	// words with done on last
	// stale data is inverted so it never looks valid
	always @(posedge clk_i)
	begin
		if (!rst_n_i || !pull_i)
		begin
			wv_o <= 1'b0;
			done_o <= 1'b0;
			sent <= 4'h0;
			gc <= 4'h0;
			word_o <= rst_n_i ? ~word_o : 32'h5A5A_5A5A;
		end
		else if (sent < nw_i && gc >= gap_i)
		begin
			wv_o <= 1'b1;
			done_o <= (sent == nw_i - 4'h1);
			word_o <= 32'hA500_0000 + 32'(sent);
			sent <= sent + 4'h1;
			gc <= 4'h0;
		end
		else
		begin
			wv_o <= 1'b0;
			done_o <= 1'b0;
			gc <= gc + 4'h1;
			word_o <= ~word_o;
		end
	end
endmodule : sbc_cp_model

/* tb/testbench.sv */
// self-checking bench for the decode and execute unit
`timescale 1ns/1ps
module testbench;
	localparam logic [23:0] MODES = 24'hCB5602;
	logic core_clk_i;
	logic rst_n_i;
	sbc_pkg::sbc_axi_in_t ai;
	sbc_pkg::sbc_axi_out_t ao;
	logic barrier, req, pull, resp, acc, wv, done, mwr, fault;
	logic cp_long, cp_alt, acc_cfg;
	logic [3:0] cp_num, cp_src, nw, gap, dly;
	logic [7:0] cp_opt;
	logic [31:0] word, maddr, mdata;
	logic [31:0] mq_a[$];
	logic [31:0] mq_d[$];
	logic [17:0] cap;
	int error_cnt, n_checks, nbar, nreq, j;

	sbc_unit dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.axi_i(ai), .axi_o(ao), .barrier_o(barrier), .cp_req_o(req),
		.cp_num_o(cp_num), .cp_src_reg_o(cp_src), .cp_long_o(cp_long),
		.cp_alt_o(cp_alt), .cp_option_o(cp_opt), .cp_resp_i(resp),
		.cp_accept_i(acc), .cp_pull_o(pull), .cp_word_valid_i(wv),
		.cp_word_i(word), .cp_done_i(done), .mem_wr_o(mwr),
		.mem_addr_o(maddr), .mem_data_o(mdata), .usage_fault_a_o(fault));
	sbc_cp_model cpm (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.pull_i(pull), .acc_i(acc_cfg), .nw_i(nw), .gap_i(gap),
		.dly_i(dly), .resp_o(resp), .accept_o(acc), .wv_o(wv),
		.word_o(word), .done_o(done));

	// clock
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// watch pulses and offered fields away from the edge
	always @(negedge core_clk_i)
	begin
		if (mwr)
		begin
			mq_a.push_back(maddr);
			mq_d.push_back(mdata);
		end
		if (barrier)
			nbar++;
		if (req)
		begin
			nreq++;
			cap = {cp_alt, cp_long, cp_num, cp_src, cp_opt};
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	task automatic hang(input string nm);
		error_cnt++;
		$display("unexpected %s: expected an answer, seen none", nm);
		summarize();
	endtask : hang

	// bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, hb;
		logic [1:0] rs;
		int i;
		hb = 1'b0;
		@(posedge core_clk_i);
		ai.awvalid <= 1'b1;
		ai.awaddr <= a;
		ai.wvalid <= 1'b1;
		ai.wdata <= d;
		ai.bready <= 1'b1;
		for (i = 0; i < 64 && !hb; i++)
		begin
			@(negedge core_clk_i);
			ta = ai.awvalid & ao.awready;
			tw = ai.wvalid & ao.wready;
			hb = ao.bvalid;
			rs = ao.bresp;
			@(posedge core_clk_i);
			if (ta)
				ai.awvalid <= 1'b0;
			if (tw)
				ai.wvalid <= 1'b0;
			if (hb)
				ai.bready <= 1'b0;
		end
		if (!hb)
			hang("bvalid");
		else
			chk("bresp", 32'(er), 32'(rs));
	endtask : wr

	// bus read
	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] q);
		logic ta, hr;
		logic [1:0] rs;
		int i;
		hr = 1'b0;
		@(posedge core_clk_i);
		ai.arvalid <= 1'b1;
		ai.araddr <= a;
		ai.rready <= 1'b1;
		for (i = 0; i < 64 && !hr; i++)
		begin
			@(negedge core_clk_i);
			ta = ai.arvalid & ao.arready;
			hr = ao.rvalid;
			q = ao.rdata;
			rs = ao.rresp;
			@(posedge core_clk_i);
			if (ta)
				ai.arvalid <= 1'b0;
			if (hr)
				ai.rready <= 1'b0;
		end
		if (!hr)
			hang("rvalid");
		else
			chk("rresp", 32'(er), 32'(rs));
	endtask : rd

	// issue one instruction, poll status until it settles
	task automatic run(input logic [31:0] ins, input logic c,
		output logic [31:0] st);
		int i;
		wr(sbc_pkg::OFS_INSTR, ins, sbc_pkg::RESP_OK);
		wr(sbc_pkg::OFS_CTRL, {30'h0, c, 1'b1}, sbc_pkg::RESP_OK);
		st = '0;
		for (i = 0; i < 40 && (st & 32'h5A) == 0; i++)
			rd(sbc_pkg::OFS_STAT, sbc_pkg::RESP_OK, st);
		if ((st & 32'h5A) == 0)
			hang("status");
	endtask : run

	// expected packed differences and flags
	function automatic logic [35:0] psub(input logic [31:0] a,
		input logic [31:0] b, input logic q);
		logic [35:0] r;
		int i, d;
		r = '0;
		for (i = 0; i < 4; i++)
			if (q)
			begin
				d = $signed(a[i*8+:8]) - $signed(b[i*8+:8]);
				r[i*8+:8] = d[7:0];
				r[32+i] = (d >= 0);
			end
			else if (i < 2)
			begin
				d = $signed(a[i*16+:16]) - $signed(b[i*16+:16]);
				r[i*16+:16] = d[15:0];
				r[32+2*i+:2] = {2{d >= 0}};
			end
		return r;
	endfunction : psub

	// reset status and unmapped offset
	task automatic t_map;
		logic [31:0] q;
		rd(sbc_pkg::OFS_STAT, sbc_pkg::RESP_OK, q);
		chk("stat_reset", 32'h0, q);
		wr(8'h40, 32'hFFFF_FFFF, sbc_pkg::RESP_SLVERR);
		rd(8'h40, sbc_pkg::RESP_SLVERR, q);
		chk("unmapped_data", 32'h0, q);
		run(32'h0000_0000, 1'b0, q);
		chk("unknown_op", 32'h42, q & 32'h7F);
		$display("test map done");
	endtask : t_map

	// packed subtract; byte form names r13 as destination
	task automatic t_sub(input logic q, input logic [31:0] a,
		input logic [31:0] b);
		logic [31:0] st;
		logic [35:0] e;
		e = psub(a, b, q);
		wr(sbc_pkg::OFS_OPA, a, sbc_pkg::RESP_OK);
		wr(sbc_pkg::OFS_OPB, b, sbc_pkg::RESP_OK);
		run(q ? (sbc_pkg::S8_MATCH | 32'h0002_0D03)
			: (sbc_pkg::S16_MATCH | 32'h0002_0103), 1'b0, st);
		chk("flags", {20'h0, e[35:32], 5'h08, q, 2'h0}, st & 32'hFFF);
		rd(sbc_pkg::OFS_RES, sbc_pkg::RESP_OK, st);
		chk("result", e[31:0], st);
		$display("test subtract %0d done", q);
	endtask : t_sub

	// barrier outside and inside a conditional block
	task automatic t_bar(input logic c);
		logic [31:0] st;
		int n0;
		n0 = nbar;
		run(sbc_pkg::BAR_MATCH, c, st);
		chk("fences", 32'h1, 32'(nbar - n0));
		chk("bar_status", 32'h40 | 32'(c) << 2, st & 32'hFF);
		$display("test barrier %0d done", c);
	endtask : t_bar

	// coproc store in one addressing form, accepted or refused
	task automatic t_cps(input int i, input logic a);
		logic [3:0] mo, rn, cp;
		logic [7:0] im;
		logic [31:0] st, ins, oa, sa, bs;
		int k, n0;
		mo = MODES[23-4*i-:4];
		rn = (i == 3) ? 4'hF : 4'h4;
		cp = 4'(i * 5);
		im = (i == 0) ? 8'h00 : (i == 3) ? 8'h5A : 8'hFF;
		bs = 32'h0000_2000;
		oa = mo[2] ? bs + {22'h0, im, 2'h0} : bs - {22'h0, im, 2'h0};
		sa = mo[3] ? oa : bs;
		ins = 32'hEC00_7000 | 32'(i[0]) << 28 | 32'(mo) << 21;
		ins = ins | 32'(rn) << 16 | 32'(cp) << 8 | 32'(im);
		acc_cfg <= a;
		nw <= 4'(i + 1);
		gap <= 4'(i % 2);
		dly <= 4'(i);
		wr(sbc_pkg::OFS_BASE, bs, sbc_pkg::RESP_OK);
		mq_a.delete();
		mq_d.delete();
		n0 = nreq;
		run(ins, 1'b0, st);
		chk("writes", (a && i < 4) ? i + 1 : 0, mq_a.size());
		if (i > 3)
		begin
			chk("redirect", 32'(i == 5), 32'(st[4]));
			chk("undefined", 32'(i == 4), 32'(st[1]));
			chk("offers", 32'h0, 32'(nreq - n0));
		end
		else
		begin
			chk("fault_pin", 32'(!a), 32'(fault));
			chk("cp_status", a ? 32'h40 | 32'(mo[0]) << 5
				| 32'(rn == 4'hF) << 2 : 32'h48, st & 32'h7F);
			chk("fields", {i[0], mo[1], cp, 4'h7, im}, cap);
			rd(sbc_pkg::OFS_WBK, sbc_pkg::RESP_OK, st);
			if (a)
				chk("wback", mo[0] ? oa : bs, st);
			for (k = 0; k < mq_a.size(); k++)
			begin
				chk("addr", sa + 32'(4 * k), mq_a[k]);
				chk("data", 32'hA500_0000 + 32'(k), mq_d[k]);
			end
		end
		$display("test store %0d accept %0d done", i, a);
	endtask : t_cps

	// main sequence
	initial
	begin
		rst_n_i = 1'b0;
		ai = '0;
		ai.wstrb = 4'hF;
		acc_cfg = 1'b1;
		nw = 4'h1;
		gap = 4'h0;
		dly = 4'h0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		t_map();
		t_sub(1'b0, 32'h7FFF_0001, 32'h8000_0002);
		t_sub(1'b1, 32'h7F80_0010, 32'h807F_0011);
		t_bar(1'b0);
		t_bar(1'b1);
		t_cps(0, 1'b0);
		for (j = 0; j < 6; j++)
			t_cps(j, 1'b1);
		summarize();
	end
endmodule : testbench
